/* File: logic/data_memory_segment_mapper.sv */
/*
  core memory organisation: segment-extended data memory with pointer
  registers and stack, program counter and program store, accumulator unit.
  assumes the core's fetch and execute logic drives one request of each
  kind per enabled cycle and takes every answer one enabled cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module data_memory_segment_mapper (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire mapper_pkg::data_req_type data_req,
  output var mapper_pkg::data_rsp_type data_rsp,
  input wire mapper_pkg::prog_req_type prog_req,
  output var mapper_pkg::prog_rsp_type prog_rsp,
  input wire mapper_pkg::alu_req_type alu_req,
  output var mapper_pkg::alu_rsp_type alu_rsp,
  output var mapper_pkg::pc_type pc,
  output var mapper_pkg::pointer_view_type pointers
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mapper_pkg::pc_type pc;
    logic [7:0] acc;
    logic carry;
    logic acc_bit;
    logic [7:0] sp;
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] s;
    mapper_pkg::data_rsp_type drsp;
    mapper_pkg::prog_rsp_type prsp;
  } core_state_type;

  // storage keeps its contents across reset
  typedef struct packed {
    logic [mapper_pkg::RAM_ENTRIES-1:0][7:0] ram;
    logic [mapper_pkg::PROG_BYTES-1:0][7:0] prog;
  } storage_type;

  core_state_type st_q;
  core_state_type st_d;
  storage_type mem_q;
  storage_type mem_d;

  logic [7:0] ea;
  logic [7:0] seg;
  logic [7:0] cur;
  logic [7:0] nv;
  logic [7:0] mask;
  logic [8:0] idx;
  logic [1:0] seg_m1;
  logic [8:0] alu_sum;
  logic [14:0] pc_flat;
  logic hit_ram;
  logic hit_ptr;
  logic in_regs;
  logic do_write;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    mem_d = mem_q;
    ea = data_req.addr;
    seg = st_q.s;
    hit_ram = 1'b0;
    hit_ptr = 1'b0;
    idx = '0;
    cur = '0;
    nv = '0;
    seg_m1 = '0;
    alu_sum = '0;
    do_write = 1'b0;
    pc_flat = st_q.pc;
    mask = 8'(8'h01 << data_req.bit_sel);
    st_d.drsp.valid = 1'b0;
    st_d.prsp.valid = 1'b0;

    // effective address from instruction or pointer
    case (data_req.mode)
      mapper_pkg::ptr_primary: begin
        ea = st_q.b; // R3
      end
      mapper_pkg::ptr_alternate: begin
        ea = st_q.x; // R3
      end
      mapper_pkg::ptr_stack: begin
        seg = '0; // R17
        ea = (data_req.op == mapper_pkg::dop_pop) ?
             8'(st_q.sp + 8'h01) : st_q.sp;
      end
      default: begin
        ea = data_req.addr;
      end
    endcase

    // decode into RAM index or pointer byte
    in_regs = ea[7] && (ea >= mapper_pkg::REG_BASE);
    if (ea[7]) begin // R15
      if (ea >= mapper_pkg::ALT_PTR_ADDR) begin
        hit_ptr = 1'b1; // R13
      end else if (in_regs) begin
        hit_ram = 1'b1; // R12
        idx = mapper_pkg::REG_RAM_BASE + {5'h00, ea[3:0]};
      end
    end else if (seg == 8'h00) begin
      if (ea <= mapper_pkg::SEG0_RAM_TOP) begin // R18
        hit_ram = 1'b1;
        idx = {1'b0, ea};
      end
    end else if (seg < mapper_pkg::SEGMENT_COUNT) begin // R16
      hit_ram = 1'b1;
      seg_m1 = 2'(seg[1:0] - 2'h1);
      idx = mapper_pkg::EXT_RAM_BASE + {seg_m1, ea[6:0]}; // R19 R11
    end

    // current value; empty addresses read zero
    if (hit_ptr) begin
      case (ea[1:0])
        2'h0: cur = st_q.x;
        2'h1: cur = st_q.sp;
        2'h2: cur = st_q.b;
        default: cur = st_q.s;
      endcase
    end else if (hit_ram) begin
      cur = mem_q.ram[idx];
    end // R20

    case (data_req.op)
      mapper_pkg::dop_write, mapper_pkg::dop_push: begin
        nv = data_req.wdata;
        do_write = 1'b1;
      end
      mapper_pkg::dop_bit_set: begin
        nv = cur | mask; // R14
        do_write = 1'b1;
      end
      mapper_pkg::dop_bit_clear: begin
        nv = cur & ~mask; // R14
        do_write = 1'b1;
      end
      mapper_pkg::decrement_skip_zero_op: begin
        nv = 8'(cur - 8'h01); // R12
        do_write = in_regs;
      end
      default: begin
        nv = cur;
      end
    endcase

    if (data_req.valid) begin
      if (do_write && hit_ram) begin
        mem_d.ram[idx] = nv;
      end
      if (do_write && hit_ptr) begin
        case (ea[1:0])
          2'h0: st_d.x = nv;
          2'h1: st_d.sp = nv;
          2'h2: st_d.b = nv;
          default: st_d.s = nv;
        endcase
      end
      // pointer motion overrides a write to the same pointer
      if (data_req.op == mapper_pkg::dop_push) begin
        st_d.sp = 8'(st_q.sp - 8'h01); // R4
      end else if (data_req.op == mapper_pkg::dop_pop) begin
        st_d.sp = 8'(st_q.sp + 8'h01);
      end
      if (data_req.mode == mapper_pkg::ptr_primary) begin
        if (data_req.post == mapper_pkg::post_inc) begin
          st_d.b = 8'(st_q.b + 8'h01); // R3
        end else if (data_req.post == mapper_pkg::post_dec) begin
          st_d.b = 8'(st_q.b - 8'h01); // R3
        end
      end
      if (data_req.mode == mapper_pkg::ptr_alternate) begin
        if (data_req.post == mapper_pkg::post_inc) begin
          st_d.x = 8'(st_q.x + 8'h01); // R3
        end else if (data_req.post == mapper_pkg::post_dec) begin
          st_d.x = 8'(st_q.x - 8'h01); // R3
        end
      end
      st_d.drsp.valid = 1'b1;
      st_d.drsp.rdata = (data_req.op == mapper_pkg::decrement_skip_zero_op
                         && in_regs) ? nv : cur;
      st_d.drsp.bit_value = (cur & mask) != 8'h00; // R14
      st_d.drsp.skip = (data_req.op == mapper_pkg::decrement_skip_zero_op)
                       && in_regs && (nv == 8'h00); // R12
      st_d.drsp.mapped = hit_ram || hit_ptr;
    end

    // program fetch at the current counter
    if (prog_req.fetch) begin
      st_d.prsp.valid = 1'b1;
      if (pc_flat == mapper_pkg::TRAP_ADDR) begin
        st_d.prsp.code = mapper_pkg::SOFTWARE_TRAP_OP; // R9
      end else if (pc_flat < 15'(mapper_pkg::PROG_BYTES)) begin
        st_d.prsp.code = mem_q.prog[pc_flat[12:0]]; // R5
      end else begin
        st_d.prsp.code = mapper_pkg::ERASED_BYTE;
      end
      st_d.prsp.trap = st_d.prsp.code == mapper_pkg::SOFTWARE_TRAP_OP; // R9
    end

    case (prog_req.pc_op)
      mapper_pkg::pc_step: begin
        st_d.pc = 15'(pc_flat + 15'h0001); // R2
      end
      mapper_pkg::pc_load: begin
        st_d.pc = prog_req.target;
      end
      mapper_pkg::pc_vector: begin
        st_d.pc = mapper_pkg::INT_VECTOR; // R6
      end
      mapper_pkg::pc_return: begin
        st_d.pc = (st_q.sp == mapper_pkg::SP_RESET) ?
                  mapper_pkg::TRAP_ADDR : prog_req.target; // R8
      end
      default: begin
        st_d.pc = st_q.pc;
      end
    endcase

    // page erase leaves bytes at the erased value
    if (prog_req.erase) begin
      for (int i = 0; i < mapper_pkg::PAGE_BYTES; i++) begin
        mem_d.prog[{prog_req.waddr[12:6], 6'(i)}] =
          mapper_pkg::ERASED_BYTE; // R10 R7
      end
    end else if (prog_req.write) begin
      mem_d.prog[prog_req.waddr] = prog_req.wdata;
    end

    // accumulator unit, one operation per enabled cycle
    case (alu_req.op)
      mapper_pkg::alu_add: begin
        alu_sum = {1'b0, st_q.acc} + {1'b0, alu_req.operand}; // R1
        st_d.acc = alu_sum[7:0];
        st_d.carry = alu_sum[8];
      end
      mapper_pkg::alu_sub: begin
        alu_sum = {1'b0, st_q.acc} - {1'b0, alu_req.operand}; // R1
        st_d.acc = alu_sum[7:0];
        st_d.carry = ~alu_sum[8];
      end
      mapper_pkg::alu_and: begin
        st_d.acc = st_q.acc & alu_req.operand; // R1
      end
      mapper_pkg::alu_or: begin
        st_d.acc = st_q.acc | alu_req.operand;
      end
      mapper_pkg::alu_xor: begin
        st_d.acc = st_q.acc ^ alu_req.operand;
      end
      mapper_pkg::alu_shl: begin
        st_d.acc = {st_q.acc[6:0], 1'b0}; // R1
        st_d.carry = st_q.acc[7];
      end
      mapper_pkg::alu_shr: begin
        st_d.acc = {1'b0, st_q.acc[7:1]};
        st_d.carry = st_q.acc[0];
      end
      mapper_pkg::alu_load: begin
        st_d.acc = alu_req.operand;
      end
      mapper_pkg::alu_test: begin
        st_d.acc_bit = st_q.acc[alu_req.bit_sel]; // R14
      end
      default: begin
        st_d.acc = st_q.acc;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.pc <= mapper_pkg::PC_START; // R7
      st_q.sp <= mapper_pkg::SP_RESET; // R4
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      mem_q <= mem_d;
    end
  end

  assign data_rsp = st_q.drsp;
  assign prog_rsp = st_q.prsp;
  assign pc = st_q.pc;
  assign alu_rsp = '{acc: st_q.acc, carry: st_q.carry,
                     bit_value: st_q.acc_bit};
  assign pointers = '{alternate_ram_pointer: st_q.x,
                      stack_top_pointer: st_q.sp,
                      primary_ram_pointer: st_q.b,
                      data_segment_extension: st_q.s};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence push_s(logic [7:0] v);
    clk_en && data_req.valid && data_req.op == mapper_pkg::dop_push
    && data_req.mode == mapper_pkg::ptr_stack && data_req.wdata == v
    && st_q.sp <= mapper_pkg::SEG0_RAM_TOP;
  endsequence

  sequence pop_s;
    clk_en && data_req.valid && data_req.op == mapper_pkg::dop_pop
    && data_req.mode == mapper_pkg::ptr_stack
    && prog_req.pc_op != mapper_pkg::pc_return;
  endsequence

  sequence reg_write_s;
    clk_en && data_req.valid && data_req.op == mapper_pkg::dop_write
    && data_req.mode == mapper_pkg::ptr_direct && data_req.addr == 8'hf3;
  endsequence

  sequence reg_read_s;
    clk_en && data_req.valid && data_req.op == mapper_pkg::dop_read
    && data_req.mode == mapper_pkg::ptr_direct && data_req.addr == 8'hf3;
  endsequence

  reset_start_a: assert property ($fell(rst) |-> st_q.pc == 15'h0000 // R7
    && st_q.sp == 8'h6f)
    else $error("counter or stack pointer wrong after reset");

  push_step_a: assert property ( // R4
    clk_en && data_req.valid && data_req.op == mapper_pkg::dop_push
    |=> st_q.sp == 8'($past(st_q.sp) - 8'h01))
    else $error("push did not decrement the stack pointer");

  stack_seg_a: assert property ( // R17
    push_s(data_req.wdata) ##1 pop_s |=> data_rsp.rdata == $past(nv, 2)
    && st_q.s == $past(st_q.s, 2))
    else $error("pop did not return the pushed byte in segment zero");

  upper_base_a: assert property ( // R15
    reg_write_s ##1 reg_read_s |=> data_rsp.rdata == $past(data_req.wdata, 2))
    else $error("register byte moved with the segment value");

  lower_hole_a: assert property ( // R18
    clk_en && data_req.valid && data_req.mode == mapper_pkg::ptr_direct
    && st_q.s == 8'h00 && data_req.addr[7:4] == 4'h7
    |=> !data_rsp.mapped && data_rsp.rdata == 8'h00)
    else $error("empty segment zero address answered as RAM");

  post_inc_a: assert property ( // R3
    clk_en && data_req.valid && data_req.mode == mapper_pkg::ptr_primary
    && data_req.post == mapper_pkg::post_inc
    |=> st_q.b == 8'($past(st_q.b) + 8'h01))
    else $error("primary pointer did not post-increment");

  vector_a: assert property ( // R6
    clk_en && prog_req.pc_op == mapper_pkg::pc_vector
    |=> pc == mapper_pkg::pc_type'(15'h00ff))
    else $error("interrupt did not vector to 00ff");

  empty_return_a: assert property ( // R8
    clk_en && prog_req.pc_op == mapper_pkg::pc_return && st_q.sp == 8'h6f
    |=> pc == mapper_pkg::pc_type'(15'h1fff))
    else $error("return from empty stack did not reach the trap");

  trap_fetch_a: assert property ( // R9
    clk_en && prog_req.fetch && st_q.pc == 15'h1fff
    |=> prog_rsp.valid && prog_rsp.trap && prog_rsp.code == 8'h00)
    else $error("fetch at 1fff did not return the trap opcode");

  add_one_a: assert property ( // R1
    clk_en && alu_req.op == mapper_pkg::alu_add
    |=> alu_rsp.acc == 8'($past(st_q.acc) + $past(alu_req.operand)))
    else $error("add did not complete in one cycle");

endmodule // data_memory_segment_mapper

`default_nettype wire

/* File: logic/mapper_pkg.sv */
/*
  constants, encodings and carrier types of the core memory organisation:
  data-memory segment mapping, stack and pointer registers, program counter,
  program store and accumulator unit.
  assumes one clock, an active-high asynchronous reset and a core that
  drives request structs synchronous to that clock.
*/
// What this block does
// R1: 8-bit add, subtract, logic and shift finish in one instruction cycle.
// R2: program counter is 15 bits, upper 7 and lower 8, not data-mapped.
// R3: primary and alternate 8-bit pointers may post-increment or decrement.
// R4: stack pointer resets to 6f, push decrements it, points at next free.
// R5: program store holds 8192 bytes, fetchable as code or table data.
// R6: every interrupt vectors execution to program address 00ff.
// R7: execution starts at address 0 after reset; erased bytes read 00.
// R8: return with stack pointer at 6f continues at program address 1fff.
// R9: fetch at 1fff returns 00, the software trap opcode, raising a trap.
// R10: program store erases and rewrites in 64-byte pages.
// R11: data memory holds 512 bytes of RAM in total.
// R12: bytes 0f0 to 0ff are registers: immediate load and decrement-skip.
// R13: alternate, stack, primary pointer and segment sit at 0fc to 0ff.
// R14: any data bit may be set, cleared, tested; accumulator bits tested.
// R15: addresses 80 to ff ignore the segment register.
// R16: addresses 00 to 7f take the segment register as upper address byte.
// R17: push and pop always use segment zero and leave segment unchanged.
// R18: segment zero has RAM at 00 to 6f only; 70 to 7f are empty.
// R19: RAM beyond the first 128 bytes sits in 128-byte segment windows.
// R20: unpopulated addresses ignore writes and read without side effects.
package mapper_pkg;

  // ----------------------------------------------------------------
  // sizes and addresses
  // ----------------------------------------------------------------
  localparam int PROG_BYTES = 32'h2000;
  localparam int PAGE_BYTES = 32'h40;
  localparam int TOTAL_RAM_BYTES = 32'h200;
  localparam int POINTER_BYTES = 32'h4;
  localparam int RAM_ENTRIES = TOTAL_RAM_BYTES - POINTER_BYTES;
  localparam logic [7:0] SEG0_RAM_TOP = 8'h6f;
  localparam logic [7:0] REG_BASE = 8'hf0;
  localparam logic [7:0] ALT_PTR_ADDR = 8'hfc;
  localparam logic [7:0] STACK_PTR_ADDR = 8'hfd;
  localparam logic [7:0] PRIMARY_PTR_ADDR = 8'hfe;
  localparam logic [7:0] SEGMENT_ADDR = 8'hff;
  localparam logic [7:0] SEGMENT_COUNT = 8'h04;
  localparam logic [8:0] REG_RAM_BASE = 9'h070;
  localparam logic [8:0] EXT_RAM_BASE = 9'h07c;

  // ----------------------------------------------------------------
  // reset values and fixed program addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [14:0] PC_START = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h00ff;
  localparam logic [14:0] TRAP_ADDR = 15'h1fff;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] SOFTWARE_TRAP_OP = 8'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ptr_direct = 2'b00, ptr_primary = 2'b01,
    ptr_alternate = 2'b10, ptr_stack = 2'b11
  } addr_mode_type;

  typedef enum logic [2:0] {
    dop_read = 3'b000, dop_write = 3'b001, dop_bit_set = 3'b010,
    dop_bit_clear = 3'b011, dop_bit_test = 3'b100,
    decrement_skip_zero_op = 3'b101, dop_push = 3'b110, dop_pop = 3'b111
  } data_op_type;

  typedef enum logic [1:0] {
    post_none = 2'b00, post_inc = 2'b01, post_dec = 2'b10
  } post_mod_type;

  typedef enum logic [2:0] {
    pc_hold = 3'b000, pc_step = 3'b001, pc_load = 3'b010,
    pc_vector = 3'b011, pc_return = 3'b100
  } pc_op_type;

  typedef enum logic [3:0] {
    alu_none = 4'h0, alu_add = 4'h1, alu_sub = 4'h2, alu_and = 4'h3,
    alu_or = 4'h4, alu_xor = 4'h5, alu_shl = 4'h6, alu_shr = 4'h7,
    alu_load = 4'h8, alu_test = 4'h9
  } alu_op_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    addr_mode_type mode;
    data_op_type op;
    post_mod_type post;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } data_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic bit_value;
    logic skip;
    logic mapped;
  } data_rsp_type;

  typedef struct packed {
    logic [6:0] counter_upper_part;
    logic [7:0] counter_lower_part;
  } pc_type;

  typedef struct packed {
    pc_op_type pc_op;
    logic [14:0] target;
    logic fetch;
    logic write;
    logic erase;
    logic [12:0] waddr;
    logic [7:0] wdata;
  } prog_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic trap;
  } prog_rsp_type;

  typedef struct packed {
    alu_op_type op;
    logic [7:0] operand;
    logic [2:0] bit_sel;
  } alu_req_type;

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic bit_value;
  } alu_rsp_type;

  typedef struct packed {
    logic [7:0] alternate_ram_pointer;
    logic [7:0] stack_top_pointer;
    logic [7:0] primary_ram_pointer;
    logic [7:0] data_segment_extension;
  } pointer_view_type;

endpackage

/* File: bench/core_side_model.sv */
/*
  model of the core's fetch and execute side: drives data, program and
  accumulator requests on the falling edge of core_clk.
  assumes callers enter its tasks in step with core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module core_side_model (
  input wire logic core_clk,
  output var logic clk_en,
  output var mapper_pkg::data_req_type data_req,
  output var mapper_pkg::prog_req_type prog_req,
  output var mapper_pkg::alu_req_type alu_req
);
  logic slow;

  initial begin
    clk_en = 1'b1;
    slow = 1'b0;
    data_req = '0;
    prog_req = '0;
    alu_req = '0;
  end

  // valid stays up across calls, so prompt requests run back to back
  task automatic data_go(input mapper_pkg::data_req_type r);
    if (slow) begin
      @(negedge core_clk);
      data_req.valid = 1'b0;
    end
    @(negedge core_clk);
    data_req = r;
    @(posedge core_clk);
  endtask

  task automatic set_enable(input logic en);
    @(negedge core_clk);
    clk_en = en;
  endtask

  task automatic data_idle();
    @(negedge core_clk);
    data_req.valid = 1'b0;
  endtask

  // program and accumulator requests are levels: one cycle each
  task automatic prog_go(input mapper_pkg::prog_req_type r);
    @(negedge core_clk);
    prog_req = r;
    @(negedge core_clk);
    prog_req = '0;
  endtask

  task automatic alu_go(input mapper_pkg::alu_req_type r);
    @(negedge core_clk);
    alu_req = r;
    @(negedge core_clk);
    alu_req = '0;
  endtask
endmodule // core_side_model

`default_nettype wire

/* File: bench/data_memory_segment_mapper_tb_top.sv */
/*
  self-checking bench for the memory organisation block.
  assumes core_side_model drives all requests; answers are queued here.
*/
`timescale 1ns/1ps
`default_nettype none

module data_memory_segment_mapper_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en;
  mapper_pkg::data_req_type data_req;
  mapper_pkg::data_rsp_type data_rsp;
  mapper_pkg::prog_req_type prog_req;
  mapper_pkg::prog_rsp_type prog_rsp;
  mapper_pkg::alu_req_type alu_req;
  mapper_pkg::alu_rsp_type alu_rsp;
  mapper_pkg::pc_type pc;
  mapper_pkg::pointer_view_type pointers;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'hc713;
  logic [21:0] dq [$];
  logic [8:0] pq [$];
  logic [21:0] e;

  always #10 core_clk = ~core_clk;

  data_memory_segment_mapper DUT (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .data_req(data_req), .data_rsp(data_rsp),
    .prog_req(prog_req), .prog_rsp(prog_rsp), .alu_req(alu_req),
    .alu_rsp(alu_rsp), .pc(pc), .pointers(pointers));

  core_side_model core (.core_clk(core_clk), .clk_en(clk_en),
    .data_req(data_req), .prog_req(prog_req), .alu_req(alu_req));

  // ----------------------------------------------------------------
  // comparison and request helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] ex, got);
    n_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // expected layout: rdata, bit_value, skip, mapped; ev under mask em
  task automatic dop(input logic [1:0] md, input logic [2:0] op,
      input logic [1:0] pm, input logic [2:0] bs, input logic [7:0] ad,
      input logic [7:0] wd, input logic [10:0] ev, input logic [10:0] em);
    dq.push_back({ev, em});
    core.data_go({1'b1, md, op, pm, bs, ad, wd});
  endtask

  task automatic wr(input logic [7:0] ad, wd, input logic mp);
    dop(2'b00, 3'b001, 2'b00, 3'h0, ad, wd, {10'h000, mp}, 11'h001);
  endtask

  task automatic rd(input logic [7:0] ad, v, input logic mp);
    dop(2'b00, 3'b000, 2'b00, 3'h0, ad, 8'h00, {v, 2'b00, mp}, 11'h7f9);
  endtask

  task automatic pgo(input logic [2:0] op, input logic [14:0] tg,
      input logic f, w, er, input logic [12:0] wa, input logic [7:0] wd);
    core.prog_go({op, tg, f, w, er, wa, wd});
  endtask

  task automatic fetch_at(input logic [14:0] at, input logic [8:0] ex);
    pgo(3'b010, at, 1'b0, 1'b0, 1'b0, 13'h0, 8'h00);
    pq.push_back(ex);
    pgo(3'b000, 15'h0, 1'b1, 1'b0, 1'b0, 13'h0, 8'h00);
  endtask

  // answers are matched in order against the queued notes
  always @(posedge core_clk) begin
    #1;
    if (data_rsp.valid === 1'b1) begin
      if (dq.size() == 0) check("data_queue", 1, 0);
      else begin
        e = dq.pop_front();
        check("data_rsp", e[21:11] & e[10:0], data_rsp[10:0] & e[10:0]);
      end
    end
    if (prog_rsp.valid === 1'b1) begin
      if (pq.size() == 0) check("prog_queue", 1, 0);
      else check("prog_rsp", pq.pop_front(), prog_rsp[8:0]);
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] rv [16];
    logic [7:0] v;
    logic [7:0] ea;
    logic [8:0] t;
    logic cm;
    int i;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    check("sp", 8'h6f, pointers.stack_top_pointer);
    check("pc", 15'h0, pc);
    for (i = 0; i < 16; i++) begin
      rv[i] = (i == 13) ? 8'h6f : 8'($random(seed));
      wr(8'hf0 + i[7:0], rv[i], 1'b1);
    end
    for (i = 0; i < 16; i++) rd(8'hf0 + i[7:0], rv[i], 1'b1);
    core.data_idle();
    check("pointers", {rv[12], rv[13], rv[14], rv[15]}, pointers);
    core.slow = 1'b1;
    for (i = 0; i < 6; i++) begin
      wr(8'hff, i[7:0], 1'b1);
      wr(8'h10, 8'h30 + i[7:0], i < 4);
      wr(8'h7f, 8'h50 + i[7:0], i inside {[1:3]});
    end
    for (i = 0; i < 6; i++) begin
      wr(8'hff, i[7:0], 1'b1);
      rd(8'h10, (i < 4) ? 8'h30 + i[7:0] : 8'h00, i < 4);
      rd(8'h7f, (i inside {[1:3]}) ? 8'h50 + i[7:0] : 8'h00,
        i inside {[1:3]});
      rd(8'h90, 8'h00, 1'b0);
      rd(8'hf0, rv[0], 1'b1);
    end
    core.slow = 1'b0;
    wr(8'hff, 8'h02, 1'b1);
    wr(8'hf3, 8'h5c, 1'b1);
    rd(8'hf3, 8'h5c, 1'b1);
    wr(8'hfd, 8'h6f, 1'b1);
    v = $random(seed);
    dop(2'b11, 3'b110, 2'b00, 3'h0, 8'h00, v, 11'h001, 11'h001);
    core.data_idle();
    check("sp", 8'h6e, pointers.stack_top_pointer);
    check("seg", 8'h02, pointers.data_segment_extension);
    dop(2'b11, 3'b111, 2'b00, 3'h0, 8'h00, 8'h00, {v, 3'b001}, 11'h7f9);
    dop(2'b11, 3'b110, 2'b00, 3'h0, 8'h00, v, 11'h001, 11'h001);
    dop(2'b11, 3'b111, 2'b00, 3'h0, 8'h00, 8'h00, {v, 3'b001}, 11'h7f9);
    wr(8'hff, 8'h00, 1'b1);
    rd(8'h6f, v, 1'b1);
    rd(8'hfd, 8'h6f, 1'b1);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(i[1] ? 8'hfc : 8'hfe, 8'h40, 1'b1);
      dop(i[1] ? 2'b10 : 2'b01, 3'b001, i[0] ? 2'b01 : 2'b10, 3'h0,
        8'h00, v, 11'h001, 11'h001);
      rd(i[1] ? 8'hfc : 8'hfe, i[0] ? 8'h41 : 8'h3f, 1'b1);
      rd(8'h40, v, 1'b1);
    end
    dop(2'b00, 3'b010, 2'b00, 3'd3, 8'hf5, 8'h00, 11'h001, 11'h001);
    dop(2'b00, 3'b011, 2'b00, 3'd0, 8'hf5, 8'h00, 11'h001, 11'h001);
    dop(2'b00, 3'b100, 2'b00, 3'd3, 8'hf5, 8'h00, 11'h005, 11'h005);
    dop(2'b00, 3'b100, 2'b00, 3'd0, 8'hf5, 8'h00, 11'h001, 11'h005);
    rd(8'hf5, (rv[5] | 8'h08) & 8'hfe, 1'b1);
    wr(8'hf6, 8'h02, 1'b1);
    dop(2'b00, 3'b101, 2'b00, 3'h0, 8'hf6, 8'h00, 11'h001, 11'h003);
    dop(2'b00, 3'b101, 2'b00, 3'h0, 8'hf6, 8'h00, 11'h003, 11'h003);
    rd(8'hf6, 8'h00, 1'b1);
    dop(2'b00, 3'b101, 2'b00, 3'h0, 8'h20, 8'h00, 11'h000, 11'h002);
    core.data_idle();
    pgo(3'b000, 15'h0, 1'b0, 1'b1, 1'b0, 13'h040, 8'ha5);
    pgo(3'b000, 15'h0, 1'b0, 1'b1, 1'b0, 13'h07f, 8'h5a);
    pgo(3'b000, 15'h0, 1'b0, 1'b1, 1'b0, 13'h080, 8'hc3);
    fetch_at(15'h0040, 9'h14a);
    pgo(3'b000, 15'h0, 1'b0, 1'b0, 1'b1, 13'h050, 8'h00);
    fetch_at(15'h0040, 9'h001);
    fetch_at(15'h007f, 9'h001);
    fetch_at(15'h0080, 9'h186);
    pgo(3'b011, 15'h0, 1'b0, 1'b0, 1'b0, 13'h0, 8'h00);
    check("pc", 15'h00ff, pc);
    pgo(3'b010, 15'h5a3c, 1'b0, 1'b0, 1'b0, 13'h0, 8'h00);
    check("pc_upper", 7'h5a, pc.counter_upper_part);
    check("pc_lower", 8'h3c, pc.counter_lower_part);
    pgo(3'b100, 15'h0123, 1'b0, 1'b0, 1'b0, 13'h0, 8'h00);
    check("pc", 15'h1fff, pc);
    pq.push_back(9'h001);
    pgo(3'b000, 15'h0, 1'b1, 1'b0, 1'b0, 13'h0, 8'h00);
    ea = $random(seed);
    core.alu_go({4'h8, ea, 3'h0});
    for (i = 1; i < 8; i++) begin
      v = $random(seed);
      cm = 1'b1;
      case (i)
        1: t = {1'b0, ea} + {1'b0, v};
        2: t = {ea >= v, ea - v};
        3: begin t = {1'b0, ea & v}; cm = 1'b0; end
        4: begin t = {1'b0, ea | v}; cm = 1'b0; end
        5: begin t = {1'b0, ea ^ v}; cm = 1'b0; end
        6: t = {ea, 1'b0};
        default: t = {ea[0], 1'b0, ea[7:1]};
      endcase
      core.alu_go({i[3:0], v, 3'h0});
      check("acc", t[7:0], alu_rsp.acc);
      if (cm) check("carry", t[8], alu_rsp.carry);
      ea = t[7:0];
    end
    for (i = 0; i < 8; i++) begin
      core.alu_go({4'h9, 8'h00, i[2:0]});
      check("acc_bit", ea[i], alu_rsp.bit_value);
    end
    core.set_enable(1'b0);
    core.alu_go({4'h1, 8'h01, 3'h0});
    pgo(3'b001, 15'h0, 1'b0, 1'b0, 1'b0, 13'h0, 8'h00);
    core.set_enable(1'b1);
    check("acc_frozen", ea, alu_rsp.acc);
    check("pc_frozen", 15'h1fff, pc);
    repeat (3) @(negedge core_clk);
    check("queues_left", 0, dq.size() + pq.size());
    wrap_up();
  end
endmodule // data_memory_segment_mapper_tb_top

`default_nettype wire
